// File: rtl/stc_pkg.sv
package stc_pkg;

  // ***************************************************
  // Register byte offsets
  // ***************************************************
  localparam logic [7:0] CTRL_OFS      = 8'h00;  // Control and start strobes
  localparam logic [7:0] DIV_OFS       = 8'h04;  // Offline divider values
  localparam logic [7:0] MASK_OFS      = 8'h08;  // Low-voltage reset masks
  localparam logic [7:0] WDG_OFS       = 8'h0c;  // Watchdog end count
  localparam logic [7:0] ERR_OFS       = 8'h10;  // Self-test error status
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h14;  // Sticky event status
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h18;  // Event mask
  localparam logic [7:0] STATE_OFS     = 8'h1c;  // Sequencer state

  // ***************************************************
  // Control bit positions
  // ***************************************************
  localparam int CTRL_ONLINE    = 0;  // Start online test, self-clearing
  localparam int CTRL_OFFLINE   = 1;  // Start offline test, self-clearing
  localparam int CTRL_PLL       = 2;  // Test runs with PLL enabled
  localparam int CTRL_P6        = 3;  // Include partition six
  localparam int CTRL_SHORT_SEQ = 4;  // External reset uses short sequence
  localparam int CTRL_W         = 5;

  // ***************************************************
  // Divider fields and reset values
  // ***************************************************
  localparam int         DIV_W      = 3;       // Width of one divider field
  localparam int         DIV_N      = 6;       // Dividers zero to five
  localparam logic [2:0] DIV_ONE    = 3'h0;    // Pattern for divide by one
  localparam logic [17:0] DIV_RESET = 18'h00000;
  localparam logic [15:0] WDG_RESET = 16'h0100;
  localparam int         PBRIDGE_MAX_KHZ = 66500;  // Divided clock ceiling

  // ***************************************************
  // Carriers
  // ***************************************************
  typedef struct packed {
    logic supply9;  // supply9_reset_mask
    logic supply4;  // supply4_reset_mask
    logic supply3;  // supply3_reset_mask
    logic supply2;  // supply2_reset_mask
  } stc_lvd_mask_t;

  typedef struct packed {
    logic pll_lock_error;    // pll_lock_error_flag
    logic watchdog_timeout;  // watchdog_timeout_flag
    logic hw_abort;          // hw_abort_flag
  } stc_err_t;

  typedef struct packed {
    logic supply9;      // supply9_destructive_flag set
    logic destructive;  // Destructive reset issued
    logic wdg_timeout;  // Watchdog end count reached
    logic done;         // Test finished cleanly
  } stc_evt_t;

  localparam logic [3:0] MASK_RESET = 4'h0;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_OFFLINE, ST_STUCK, ST_ONLINE, ST_WAIT_WDG
  } stc_state_t;

endpackage

// File: rtl/stc_self_test_controller.sv
`timescale 1ns/1ns

// How it works
// - Offline test with non-unity divider blocks reset exit
// - Partition six with supply 2/3/4 mask: destructive reset
// - Supply-nine mask sets destructive flag, no reset
// - Reset in window waits for watchdog end count
// - That case: abort flag unchanged, watchdog timeout set
// - With PLL enabled, also set lock error
module stc_self_test_controller #(
  parameter int TEST_CYCLES = 256,  // Length of one test run
  parameter int P6_AT       = 128,  // Cycle where partition six ends
  parameter int WIN_START   = 16,   // First cycle of reset hazard window
  parameter int WIN_END     = 200   // Last cycle of reset hazard window
) (
  // Clock and reset
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  // APB slave
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Reset sources
  input  wire  logic        ext_reset_n,
  input  wire  logic        func_reset_req,
  input  wire  logic        hw_abort_req,
  // Status outputs
  output logic              destructive_reset,
  output logic              reset_exit_ok,
  output logic              test_busy,
  output logic              irq
);

  // ***************************************************
  // Elaboration checks
  // ***************************************************
  if (TEST_CYCLES < 4 || TEST_CYCLES > 65535 || P6_AT >= TEST_CYCLES ||
      WIN_START > WIN_END || WIN_END >= TEST_CYCLES) begin : g_bad
    $error("stc_self_test_controller: bad cycle parameters");
  end

  // ***************************************************
  // State
  // ***************************************************
  stc_pkg::stc_state_t    state;        // Sequencer state
  logic [stc_pkg::CTRL_W-1:0] ctrl;     // Control bits, starts read zero
  logic [17:0]            div_cfg;      // system_clock_divider_config
  stc_pkg::stc_lvd_mask_t lvd_mask;     // low_voltage_reset_mask
  logic [15:0]            wdg_end;      // watchdog_end_count
  stc_pkg::stc_err_t      err;          // selftest_error_status
  stc_pkg::stc_evt_t      evt_stat;     // Sticky events
  stc_pkg::stc_evt_t      evt_mask;     // Event mask
  stc_pkg::stc_evt_t      evt_set;      // Event pulses this cycle
  logic [15:0]            cnt;          // Test and watchdog counter
  logic                   ext_meta;     // Pin synchroniser stage one
  logic                   ext_sync;     // Pin synchroniser stage two
  logic                   div_all_one;  // Every divider at divide-by-one
  logic                   lvd_armed;    // Supply 2/3/4 masks arm a reset
  logic                   in_window;    // Counter in hazard window
  logic                   reset_hit;    // Short-seq or functional reset
  logic                   test_end;     // Last test cycle
  logic                   p6_hit;       // Partition six completes now
  logic                   wdg_end_hit;  // Watchdog end count reached
  logic [stc_pkg::DIV_N-1:0] div_is_one; // Per-field divide-by-one
  stc_pkg::stc_err_t      err_clr;      // Write-one-to-clear mask
  // APB decode
  logic wr_en;
  logic rd_acc;
  logic rd_setup;
  logic mapped;
  assign wr_en    = psel && penable && pwrite;
  assign rd_acc   = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign mapped   = (paddr <= stc_pkg::STATE_OFS) && (paddr[1:0] == 2'b00);  // Aligned words up to state
  assign pslverr  = psel && penable && !mapped;
  assign err_clr  = (wr_en && paddr == stc_pkg::ERR_OFS) ? stc_pkg::stc_err_t'(pwdata[2:0]) : '0;
  // ***************************************************
  // Condition decode
  // ***************************************************
  // unity divider check
  for (genvar gi = 0; gi < stc_pkg::DIV_N; gi++) begin : g_div
    assign div_is_one[gi] = div_cfg[gi*stc_pkg::DIV_W +: stc_pkg::DIV_W] == stc_pkg::DIV_ONE;
  end
  assign div_all_one = &div_is_one;
  assign lvd_armed   = lvd_mask.supply4 || lvd_mask.supply3 || lvd_mask.supply2;
  assign in_window   = (cnt >= 16'(WIN_START)) && (cnt <= 16'(WIN_END));
  assign reset_hit   = (!ext_sync && ctrl[stc_pkg::CTRL_SHORT_SEQ]) || func_reset_req;
  assign test_end    = cnt == 16'(TEST_CYCLES - 1);
  assign p6_hit      = ctrl[stc_pkg::CTRL_P6] && (cnt == 16'(P6_AT));
  assign wdg_end_hit = cnt >= wdg_end;
  // Pin synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b1;
      ext_sync <= 1'b1;
    end else begin
      ext_meta <= ext_reset_n;
      ext_sync <= ext_meta;
    end
  end

  // ***************************************************
  // Sequencer
  // ***************************************************
  // State and counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= stc_pkg::ST_IDLE;
      cnt   <= 16'h0000;
    end else begin
      case (state)
        stc_pkg::ST_IDLE: begin
          cnt <= 16'h0000;
          if (wr_en && paddr == stc_pkg::CTRL_OFS && pwdata[stc_pkg::CTRL_OFFLINE]) begin
            state <= stc_pkg::ST_OFFLINE;
          end else if (wr_en && paddr == stc_pkg::CTRL_OFS && pwdata[stc_pkg::CTRL_ONLINE]) begin
            state <= stc_pkg::ST_ONLINE;
          end
        end
        stc_pkg::ST_OFFLINE: begin
          cnt <= cnt + 16'h0001;
          if (test_end) begin
            state <= div_all_one ? stc_pkg::ST_IDLE : stc_pkg::ST_STUCK;
          end
        end
        stc_pkg::ST_STUCK: begin
          state <= stc_pkg::ST_STUCK;  // Held until the next reset
        end
        stc_pkg::ST_ONLINE: begin
          cnt <= cnt + 16'h0001;
          if (p6_hit && lvd_armed) begin
            state <= stc_pkg::ST_IDLE;
          end else if (reset_hit && in_window) begin
            state <= stc_pkg::ST_WAIT_WDG;
            cnt   <= 16'h0000;
          end else if (hw_abort_req || test_end) begin
            state <= stc_pkg::ST_IDLE;
          end
        end
        stc_pkg::ST_WAIT_WDG: begin
          cnt <= cnt + 16'h0001;
          if (wdg_end_hit) begin
            state <= stc_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= stc_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // Event pulses from sequencer
  always_comb begin
    evt_set             = '0;
    evt_set.done        = (state == stc_pkg::ST_ONLINE) && test_end && !(p6_hit && lvd_armed) &&
                          !(reset_hit && in_window) && !hw_abort_req;
    evt_set.destructive = (state == stc_pkg::ST_ONLINE) && p6_hit && lvd_armed;
    evt_set.wdg_timeout = (state == stc_pkg::ST_WAIT_WDG) && wdg_end_hit;
    evt_set.supply9     = evt_set.done && lvd_mask.supply9;
  end
  // Destructive reset and status outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      destructive_reset <= 1'b0;
      reset_exit_ok     <= 1'b1;
      test_busy         <= 1'b0;
    end else begin
      destructive_reset <= evt_set.destructive;
      reset_exit_ok     <= (state != stc_pkg::ST_STUCK) &&
                           !((state == stc_pkg::ST_OFFLINE) && test_end && !div_all_one);
      test_busy         <= (state == stc_pkg::ST_ONLINE) || (state == stc_pkg::ST_WAIT_WDG) ||
                           (state == stc_pkg::ST_OFFLINE);
    end
  end
  // Error flags, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err <= '0;
    end else begin
      err.hw_abort <= (err.hw_abort && !err_clr.hw_abort) ||
                      ((state == stc_pkg::ST_ONLINE) && hw_abort_req && !(reset_hit && in_window));
      err.watchdog_timeout <= (err.watchdog_timeout && !err_clr.watchdog_timeout) || evt_set.wdg_timeout;
      err.pll_lock_error <= (err.pll_lock_error && !err_clr.pll_lock_error) ||
                            (evt_set.wdg_timeout && ctrl[stc_pkg::CTRL_PLL]);
    end
  end

  // Sticky events, cleared by reading, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_stat <= '0;
    end else if (rd_acc && paddr == stc_pkg::IRQ_STAT_OFS) begin
      evt_stat <= evt_set;
    end else begin
      evt_stat <= evt_stat | evt_set;
    end
  end

  // Interrupt output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(evt_stat & evt_mask);
    end
  end

  // ***************************************************
  // Register writes and reads
  // ***************************************************
  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= '0;
      div_cfg  <= stc_pkg::DIV_RESET;
      lvd_mask <= stc_pkg::MASK_RESET;
      wdg_end  <= stc_pkg::WDG_RESET;
      evt_mask <= '0;
    end else if (wr_en) begin
      case (paddr)
        stc_pkg::CTRL_OFS:     ctrl     <= {pwdata[stc_pkg::CTRL_W-1:2], 2'h0};
        stc_pkg::DIV_OFS:      div_cfg  <= pwdata[17:0];
        stc_pkg::MASK_OFS:     lvd_mask <= stc_pkg::stc_lvd_mask_t'(pwdata[3:0]);
        stc_pkg::WDG_OFS:      wdg_end  <= pwdata[15:0];
        stc_pkg::IRQ_MASK_OFS: evt_mask <= stc_pkg::stc_evt_t'(pwdata[3:0]);
        default: ;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      case (paddr)
        stc_pkg::CTRL_OFS:     prdata <= {27'h0, ctrl};
        stc_pkg::DIV_OFS:      prdata <= {14'h0, div_cfg};
        stc_pkg::MASK_OFS:     prdata <= {28'h0, lvd_mask};
        stc_pkg::WDG_OFS:      prdata <= {16'h0, wdg_end};
        stc_pkg::ERR_OFS:      prdata <= {29'h0, err};
        stc_pkg::IRQ_STAT_OFS: prdata <= {28'h0, evt_stat | evt_set};
        stc_pkg::IRQ_MASK_OFS: prdata <= {28'h0, evt_mask};
        stc_pkg::STATE_OFS:    prdata <= {29'h0, state};
        default:               prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************
  // Assertions
  // ***************************************************
  bad_div_stuck_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == stc_pkg::ST_OFFLINE && test_end && !div_all_one) |=> (state == stc_pkg::ST_STUCK && !reset_exit_ok))
    else $error("offline run with bad divider left reset");
  good_div_exit_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == stc_pkg::ST_OFFLINE && test_end && div_all_one) |=> ##1 reset_exit_ok)
    else $error("offline run with unity dividers did not exit");
  p6_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == stc_pkg::ST_ONLINE && p6_hit && lvd_armed) |=> destructive_reset ##1 !destructive_reset)
    else $error("partition six reset missing");
  no_spurious_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
    destructive_reset |-> $past(lvd_armed) && $past(state == stc_pkg::ST_ONLINE))
    else $error("destructive reset without cause");
  supply9_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_set.done && lvd_mask.supply9) |=> (evt_stat.supply9 && !destructive_reset))
    else $error("supply nine flag not set");
  wait_wdg_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == stc_pkg::ST_ONLINE && reset_hit && in_window && !(p6_hit && lvd_armed))
    |=> (state == stc_pkg::ST_WAIT_WDG && cnt == 16'h0000))
    else $error("reset in window did not wait");
  timeout_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == stc_pkg::ST_WAIT_WDG && wdg_end_hit) |=> (err.watchdog_timeout && $stable(err.hw_abort)
    && state == stc_pkg::ST_IDLE))
    else $error("timeout flags wrong");
  pll_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state == stc_pkg::ST_WAIT_WDG && wdg_end_hit && ctrl[stc_pkg::CTRL_PLL]) |=> err.pll_lock_error)
    else $error("lock error not set");
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !mapped) |-> pslverr && pready)
    else $error("unmapped access not refused");

endmodule // stc_self_test_controller

// File: bench/tb_self_test_sequence_control.sv
`timescale 1ns/1ns

// Compare one value, count it, report a miss
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb_self_test_sequence_control;

  // ***************************************************
  // Signals
  // ***************************************************
  logic        pclk;            // Bus clock
  logic        presetn;         // Async reset, active low
  logic        psel;            // APB select
  logic        penable;         // APB access phase
  logic        pwrite;          // APB direction
  logic [7:0]  paddr;           // APB address
  logic [31:0] pwdata;          // APB write data
  logic [31:0] prdata;          // APB read data
  logic        pready;          // APB ready
  logic        pslverr;         // APB error
  logic        ext_reset_n;     // External reset pin
  logic        func_reset_req;  // Functional reset source
  logic        hw_abort_req;    // Hardware abort source
  logic        destructive_reset;
  logic        reset_exit_ok;
  logic        test_busy;
  logic        irq;
  logic [31:0] rd;              // Last read word
  logic        err;             // Last error response
  int          n_fail;          // Mismatch count
  int          checks;          // Comparison count
  int          n_destr;         // Destructive pulses seen

  // Small counts keep the run short
  stc_self_test_controller #(
    .TEST_CYCLES (16),
    .P6_AT       (8),
    .WIN_START   (2),
    .WIN_END     (12)
  ) dut (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .ext_reset_n       (ext_reset_n),
    .func_reset_req    (func_reset_req),
    .hw_abort_req      (hw_abort_req),
    .destructive_reset (destructive_reset),
    .reset_exit_ok     (reset_exit_ok),
    .test_busy         (test_busy),
    .irq               (irq)
  );

  // Clock generation, 8 ns period
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Count one-cycle destructive pulses
  always @(negedge pclk) begin
    if (destructive_reset === 1'b1) begin
      n_destr++;
    end
  end

  // ***************************************************
  // Tasks
  // ***************************************************
  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read one register and compare
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask

  // Reset held for four cycles
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // Bounded wait for the sequencer to go quiet
  task automatic wait_idle();
    int n;
    n = 0;
    // Busy rises one cycle after the start edge
    repeat (2) @(negedge pclk);
    while (test_busy === 1'b1 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    `CHK("busy", 1'b0, test_busy)
  endtask

  // Reset values and unmapped access
  task automatic t_regs();
    rd_chk("div", stc_pkg::DIV_OFS, 32'h0);
    rd_chk("mask", stc_pkg::MASK_OFS, 32'h0);
    rd_chk("wdg", stc_pkg::WDG_OFS, 32'h00000100);
    rd_chk("err", stc_pkg::ERR_OFS, 32'h0);
    rd_chk("hole", 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    $display("test regs done");
  endtask

  // Offline run: stuck with a divider off one, clean with all at one
  task automatic t_offline();
    apb(1'b1, stc_pkg::DIV_OFS, 32'h00000008);
    apb(1'b1, stc_pkg::CTRL_OFS, 32'h00000002);
    wait_idle();
    `CHK("exit_stuck", 1'b0, reset_exit_ok)
    rd_chk("st_stuck", stc_pkg::STATE_OFS, 32'h2);
    do_reset();
    apb(1'b1, stc_pkg::DIV_OFS, 32'h00000000);
    apb(1'b1, stc_pkg::CTRL_OFS, 32'h00000002);
    wait_idle();
    `CHK("exit_ok", 1'b1, reset_exit_ok)
    rd_chk("st_idle", stc_pkg::STATE_OFS, 32'h0);
    $display("test offline done");
  endtask

  // Start an online run with given masks
  task automatic start_online(input logic [3:0] m, input logic [31:0] c);
    apb(1'b1, stc_pkg::MASK_OFS, {28'h0, m});
    apb(1'b0, stc_pkg::IRQ_STAT_OFS, 32'h0);
    apb(1'b1, stc_pkg::CTRL_OFS, c | 32'h1);
  endtask

  // Partition six with each supply mask, then supply nine alone
  task automatic t_masks();
    int base;
    apb(1'b1, stc_pkg::IRQ_MASK_OFS, 32'h00000004);
    for (int i = 0; i < 3; i++) begin
      base = n_destr;
      start_online(4'h1 << i, 32'h00000008);
      wait_idle();
      `CHK("destr_pulse", base + 1, n_destr)
      @(negedge pclk);
      `CHK("irq_on", 1'b1, irq)
      rd_chk("stat_destr", stc_pkg::IRQ_STAT_OFS, 32'h4);
      repeat (2) @(negedge pclk);
      `CHK("irq_off", 1'b0, irq)
    end
    base = n_destr;
    start_online(4'h8, 32'h00000000);
    wait_idle();
    `CHK("no_pulse", base, n_destr)
    rd_chk("stat_s9", stc_pkg::IRQ_STAT_OFS, 32'h9);
    $display("test masks done");
  endtask

  // Reset or abort inside the hazard window
  task automatic t_window();
    logic [31:0] e_err;
    logic [31:0] e_st;
    apb(1'b1, stc_pkg::WDG_OFS, 32'h00000014);
    for (int k = 0; k < 3; k++) begin
      e_err = (k == 0) ? 32'h6 : (k == 1) ? 32'h2 : 32'h1;
      e_st = (k == 2) ? 32'h0 : 32'h2;
      start_online(4'h0, (k == 0) ? 32'h00000004 : 32'h00000010);
      repeat (5) @(posedge pclk);
      if (k == 0) func_reset_req <= 1'b1;
      else if (k == 1) ext_reset_n <= 1'b0;
      else hw_abort_req <= 1'b1;
      repeat (3) @(posedge pclk);
      func_reset_req <= 1'b0;
      ext_reset_n    <= 1'b1;
      hw_abort_req   <= 1'b0;
      wait_idle();
      rd_chk("err_flags", stc_pkg::ERR_OFS, e_err);
      rd_chk("stat_wdg", stc_pkg::IRQ_STAT_OFS, e_st);
      apb(1'b1, stc_pkg::ERR_OFS, 32'h00000007);
      rd_chk("err_clr", stc_pkg::ERR_OFS, 32'h0);
    end
    $display("test window done");
  endtask

  // Print counts and verdict, then stop
  task automatic finish_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ***************************************************
  // Sequence
  // ***************************************************
  // Hang guard, well beyond the expected run
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end

  // Main test order
  initial begin
    n_fail = 0;
    checks = 0;
    n_destr = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_reset_n = 1'b1;
    func_reset_req = 1'b0;
    hw_abort_req = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_offline();
    t_masks();
    t_window();
    finish_test();
  end

endmodule // tb_self_test_sequence_control
